// ===== fcdio_pkg.sv
// Purpose: constants shared by the four-terminal digital i/o block
// Assumes: core clock of 25 MHz (40 ns period)
// Notes:   register offsets and the direction and command reset values live here only
package fcdio_pkg;
    // ==========================================================
    // clock and timing
    localparam int unsigned CLK_PERIOD_NS      = 40;
    localparam int unsigned GLITCH_REJECT_US   = 50;
    localparam int unsigned GLITCH_REJECT_CYC  =
        (GLITCH_REJECT_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned TASK_INTERVAL_DEF  = 25000;
    // ==========================================================
    // register map (word offsets in bytes)
    localparam logic [7:0] ADDR_DIR    = 8'h00;
    localparam logic [7:0] ADDR_CMD    = 8'h04;
    localparam logic [7:0] ADDR_USED   = 8'h08;
    localparam logic [7:0] ADDR_CTRL   = 8'h0c;
    localparam logic [7:0] ADDR_INPUT  = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_IVAL   = 8'h18;
    // ==========================================================
    // control bit positions and reset values
    localparam int unsigned CTRL_RUN_BIT   = 0;
    localparam int unsigned CTRL_LOAD_BIT  = 1;
    localparam logic [3:0]  DIR_RESET      = 4'h0;
    localparam logic [3:0]  CMD_RESET      = 4'h0;
    localparam logic [31:0] UNMAPPED_READ  = 32'h0000_0000;
endpackage : fcdio_pkg

// ===== fcdio_top.sv
// Purpose: four digital terminals, each an input or an output, with
//          per-interval sampling and update, global enable and LEDs
// Assumes: one clock CORE_CLK, synchronous active-low reset NRST
// Notes:   terminal pins are open-emitter style: output enable low
//          means the driver conducts to the supply terminal
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/10ps
// Operation
// - four terminals, each independently an input or an output
// - an output terminal also feeds its input path for read back
// - status LEDs driven only while the application runs
// - input LED lights when sampled one and input is used
// - output LED lights when commanded value is one
// - LEDs follow internal state even without io supply
// - global enable low disables every output driver
// - while disabled, LEDs still show commanded output states
// - overload disables output; retries after thermal recovery
// - outputs updated once per configurable task interval
// - unconnected input reads as zero
// - inputs sampled once per task interval
// - pulses of 50 us or less never register
module fcdio_top
    import fcdio_pkg::*;
#(
    parameter int unsigned N_TERM        = 4,
    parameter int unsigned TASK_INTERVAL = TASK_INTERVAL_DEF,
    parameter int unsigned COOL_CYCLES   = 2500
) (
    input  wire logic              CORE_CLK,       // core clock
    input  wire logic              NRST,           // sync reset, low
    input  wire logic [7:0]        ADDR,           // register address
    input  wire logic [31:0]       WDATA,          // write data
    input  wire logic              WR,             // write strobe
    input  wire logic              RD,             // read strobe
    output logic      [31:0]       RDATA,          // read data
    input  wire logic [N_TERM-1:0] TERM_IN,        // terminal levels
    output logic      [N_TERM-1:0] TERM_OUT,       // driven level
    output logic      [N_TERM-1:0] TERM_OE_N,      // low: driver on
    input  wire logic [N_TERM-1:0] OVERLOAD,       // overload sense
    input  wire logic              GLOBAL_OUTPUTS_ENABLE, // from pin
    output logic      [N_TERM-1:0] STATUS_LED,     // front LEDs
    output logic                   TICK            // task interval
);
    // ==========================================================
    // elaboration checks
    if (N_TERM != 4) begin : g_nterm
        $error("fcdio_top serves exactly four terminals");
    end
    if (TASK_INTERVAL <= GLITCH_REJECT_CYC) begin : g_ival
        $error("task interval must exceed the glitch window");
    end

    function automatic logic [31:0] pad4(input logic [3:0] v);
        pad4 = {28'h0, v};
    endfunction : pad4

    // ==========================================================
    // synchronisers: three flops, change taken when 2nd and 3rd agree
    logic [N_TERM-1:0] in_s1, in_s2, in_s3, in_stable;
    logic [N_TERM-1:0] ov_s1, ov_s2, ov_s3, ov_stable;
    logic              en_s1, en_s2, en_s3, en_stable;
    always_ff @(posedge CORE_CLK) begin
        in_s1 <= TERM_IN;
        in_s2 <= in_s1;
        in_s3 <= in_s2;
        ov_s1 <= OVERLOAD;
        ov_s2 <= ov_s1;
        ov_s3 <= ov_s2;
        en_s1 <= GLOBAL_OUTPUTS_ENABLE;
        en_s2 <= en_s1;
        en_s3 <= en_s2;
    end
    wire [N_TERM-1:0] next_in_stable = (in_s2 == in_s3) ? in_s3 : in_stable;
    wire [N_TERM-1:0] next_ov_stable = (ov_s2 == ov_s3) ? ov_s3 : ov_stable;
    wire              next_en_stable = (en_s2 == en_s3) ? en_s3 : en_stable;
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            in_stable <= 4'h0;
            ov_stable <= 4'h0;
            en_stable <= 1'b0;
        end else begin
            in_stable <= next_in_stable;
            ov_stable <= next_ov_stable;
            en_stable <= next_en_stable;
        end
    end

    // ==========================================================
    // registers
    logic [3:0]  dir;         // 1 = output
    logic [3:0]  dir_shadow;  // staged until load
    logic [3:0]  cmd;         // staged commanded outputs
    logic [3:0]  cmd_live;    // applied at interval tick
    logic [3:0]  used;
    logic        run;
    logic        loaded;
    logic [31:0] ival;
    wire wr_dir  = WR && (ADDR == ADDR_DIR);
    wire wr_cmd  = WR && (ADDR == ADDR_CMD);
    wire wr_used = WR && (ADDR == ADDR_USED);
    wire wr_ctrl = WR && (ADDR == ADDR_CTRL);
    wire wr_ival = WR && (ADDR == ADDR_IVAL);
    wire do_load = wr_ctrl && WDATA[CTRL_LOAD_BIT];
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            dir_shadow <= DIR_RESET;
            dir        <= DIR_RESET;
            loaded     <= 1'b0;
            cmd        <= CMD_RESET;
            used       <= 4'h0;
            run        <= 1'b0;
            ival       <= 32'(TASK_INTERVAL);
        end else begin
            if (wr_dir)
                dir_shadow <= WDATA[3:0];
            if (do_load) begin
                dir    <= dir_shadow;
                loaded <= 1'b1;
            end
            if (wr_cmd)
                cmd <= WDATA[3:0];
            if (wr_used)
                used <= WDATA[3:0];
            if (wr_ctrl)
                run <= WDATA[CTRL_RUN_BIT];
            if (wr_ival && (WDATA > 32'(GLITCH_REJECT_CYC)))
                ival <= WDATA;
        end
    end

    // ==========================================================
    // task interval timer
    logic [31:0] tcnt;
    wire         tick_now  = (tcnt >= ival - 32'h1);
    wire [31:0]  next_tcnt = tick_now ? 32'h0 : tcnt + 32'h1;
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            tcnt <= 32'h0;
            TICK <= 1'b0;
        end else begin
            tcnt <= next_tcnt;
            TICK <= tick_now;
        end
    end

    // ==========================================================
    // glitch filter: a level must hold beyond 50 us before sampling
    // the filter adds a fixed latency of one glitch window to every edge;
    // pulses between the window and the interval pass only if a tick lands
    // one process drives every filter bit, so no bit has two drivers
    logic [N_TERM-1:0] filt;
    logic [15:0]       gcnt [N_TERM];
    logic [3:0]        sampled;
    wire  [3:0]        diff = in_stable ^ filt;
    always_ff @(posedge CORE_CLK) begin
        for (int i = 0; i < N_TERM; i++) begin
            if (!NRST) begin
                gcnt[i] <= 16'h0;
                filt[i] <= 1'b0;
            end else if (!diff[i]) begin
                gcnt[i] <= 16'h0;
            end else if (gcnt[i] >= 16'(GLITCH_REJECT_CYC)) begin
                filt[i] <= in_stable[i];
                gcnt[i] <= 16'h0;
            end else begin
                gcnt[i] <= gcnt[i] + 16'h1;
            end
        end
    end
    always_ff @(posedge CORE_CLK) begin
        if (!NRST)
            sampled <= 4'h0;
        else if (tick_now)
            sampled <= filt;
    end

    // ==========================================================
    // overload retry: drop the driver, cool, then try again
    // a load that stays shorted keeps cycling trip and retry; software
    // sees this in the status word and must act on it itself
    logic [15:0] cool [N_TERM];
    logic [3:0]  tripped;
    always_ff @(posedge CORE_CLK) begin
        for (int i = 0; i < N_TERM; i++) begin
            if (!NRST) begin
                cool[i]    <= 16'h0;
                tripped[i] <= 1'b0;
            end else if (!tripped[i]) begin
                if (ov_stable[i] && !TERM_OE_N[i]) begin
                    tripped[i] <= 1'b1;
                    cool[i]    <= 16'(COOL_CYCLES);
                end
            end else if (cool[i] == 16'h0) begin
                tripped[i] <= 1'b0;
            end else begin
                cool[i] <= cool[i] - 16'h1;
            end
        end
    end

    // ==========================================================
    // output update and drive
    wire [3:0] drive_on = cmd_live & dir & ~tripped & {4{en_stable}} & {4{loaded}};
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            cmd_live  <= 4'h0;
            TERM_OUT  <= 4'h0;
            TERM_OE_N <= 4'hf;
        end else begin
            if (tick_now)
                cmd_live <= cmd;
            TERM_OUT  <= drive_on;
            TERM_OE_N <= ~drive_on;
        end
    end

    // ==========================================================
    // status LEDs: pure logic state, independent of io supply
    wire [3:0] led_val = (dir & cmd_live) | (~dir & sampled & used);
    always_ff @(posedge CORE_CLK) begin
        if (!NRST)
            STATUS_LED <= 4'h0;
        else
            STATUS_LED <= run ? led_val : 4'h0;
    end

    // ==========================================================
    // read port; software may combine several samples itself
    wire [31:0] rd_mux =
        (ADDR == ADDR_DIR)    ? pad4(dir_shadow) :
        (ADDR == ADDR_CMD)    ? pad4(cmd) :
        (ADDR == ADDR_USED)   ? pad4(used) :
        (ADDR == ADDR_CTRL)   ? {30'h0, loaded, run} :
        (ADDR == ADDR_INPUT)  ? pad4(sampled) :
        (ADDR == ADDR_STATUS) ? {23'h0, en_stable, tripped, dir} :
        (ADDR == ADDR_IVAL)   ? ival : UNMAPPED_READ;
    always_ff @(posedge CORE_CLK) begin
        if (!NRST)
            RDATA <= 32'h0;
        else
            RDATA <= RD ? rd_mux : 32'h0;
    end

    // ==========================================================
    // assertions
    // leds and drivers are registered, so each led and driver consequent except
    // those of input_dir_a and drive_zero_a is held against the state one cycle back

    gate_off_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        !en_stable |=> &TERM_OE_N)
        else $error("driver on while outputs disabled");

    led_dark_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        !run |=> STATUS_LED == 4'h0)
        else $error("led lit while not running");

    led_out_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        run |=> (STATUS_LED & $past(dir)) == $past(cmd_live & dir))
        else $error("output led mismatch");

    led_in_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        run |=> (STATUS_LED & ~$past(dir)) == $past(sampled & used & ~dir))
        else $error("input led mismatch");

    led_unused_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        run |=> (STATUS_LED & ~$past(dir) & ~$past(used)) == 4'h0)
        else $error("led lit for unused input");

    led_disabled_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        run && !en_stable |=>
        (STATUS_LED & $past(dir)) == $past(cmd_live & dir))
        else $error("led lost while disabled");

    oe_dir_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        1'b1 |=> (~TERM_OE_N & ~$past(dir)) == 4'h0)
        else $error("input terminal driven");

    drive_cmd_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        1'b1 |=> (TERM_OUT & ~$past(cmd_live)) == 4'h0)
        else $error("driver on for commanded zero");

    trip_drop_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        1'b1 |=> (~TERM_OE_N & $past(tripped)) == 4'h0)
        else $error("tripped terminal driven");

    retry_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        $fell(tripped[0]) |-> $past(cool[0]) == 16'h0)
        else $error("retry before cooling ended");

    rst_off_a: assert property (@(posedge CORE_CLK)
        !NRST |=> &TERM_OE_N && STATUS_LED == 4'h0)
        else $error("reset state wrong");

    tick_pulse_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        TICK |=> !TICK)
        else $error("tick longer than one cycle");

    live_src_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        tick_now |=> cmd_live == $past(cmd))
        else $error("command not applied at tick");

    sample_src_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        tick_now |=> sampled == $past(filt))
        else $error("input not sampled at tick");

    ival_floor_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        ival > 32'(GLITCH_REJECT_CYC))
        else $error("interval inside glitch window");

    rdata_idle_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        !RD |=> RDATA == 32'h0)
        else $error("read data without read");

    drive_zero_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (TERM_OUT == ~TERM_OE_N))
        else $error("drive level and enable disagree");

    input_dir_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        !loaded |-> &TERM_OE_N)
        else $error("driver on before load");

    sample_tick_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        !tick_now |=> $stable(sampled))
        else $error("sample changed off tick");

    update_tick_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        !tick_now |=> $stable(cmd_live))
        else $error("output changed off tick");

    trip_off_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        $rose(tripped[0]) |=> TERM_OE_N[0])
        else $error("tripped output still driven");

    glitch_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        $changed(filt[0]) |-> $past(in_stable[0] != filt[0], 8))
        else $error("short pulse passed filter");
endmodule : fcdio_top

// ===== fcdio_field.sv
// Purpose: field side of the four terminals: sensors, loads and shorts
// Assumes: open-emitter drivers; a released terminal is pulled low by its load
// Notes:   a shorted load only trips overload while its driver conducts
`timescale 1ns/10ps
module fcdio_field (
    input  wire logic [3:0] term_out,  // driven level
    input  wire logic [3:0] term_oe_n, // low: driver on
    input  wire logic [3:0] sensor,    // sensor levels, 0 = open
    input  wire logic [3:0] shorted,   // shorted load per terminal
    output logic      [3:0] term_in,   // level seen at terminal
    output logic      [3:0] overload   // overload sense
);
    // ==========================================================
    // terminal levels
    wire logic [3:0] conducting;
    assign conducting = term_out & ~term_oe_n;
    // an output terminal is read back through its own input path
    assign term_in    = conducting | (sensor & term_oe_n);
    assign overload   = conducting & shorted;
endmodule : fcdio_field

// ===== fcdio_top_tb.sv
// Purpose: self-checking bench for the four-terminal digital i/o block
// Assumes: task interval 2000 cycles, cool-down 10 cycles
// Notes:   expectations come from a small integer model of the terminals
`timescale 1ns/10ps
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("CHECK FAILED %0t %s", $time, m); end end
module fcdio_top_tb
    import fcdio_pkg::*;
;
    localparam int unsigned TI = 2000;
    logic        clk, nrst, wr, rd, gen;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, rv, seed;
    logic [3:0]  t_in, t_out, oe_n, ovl, led, sensor, shorted;
    logic        tick;
    int          n_fail, num_checks, m_dir, m_cmd, m_used, m_run, m_en, m_in;
    fcdio_top #(.N_TERM(4), .TASK_INTERVAL(TI), .COOL_CYCLES(10)) dut (
        .CORE_CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .TERM_IN(t_in), .TERM_OUT(t_out),
        .TERM_OE_N(oe_n), .OVERLOAD(ovl), .GLOBAL_OUTPUTS_ENABLE(gen),
        .STATUS_LED(led), .TICK(tick));
    fcdio_field field (.term_out(t_out), .term_oe_n(oe_n), .sensor(sensor),
        .shorted(shorted), .term_in(t_in), .overload(ovl));
    // ==========================================================
    // helpers
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xorshift
    task automatic report_and_stop();
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    task automatic bus_wr(input logic [7:0] a, input int d);
        @(posedge clk);
        addr  <= a;
        wdata <= 32'(d);
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        rv = rdata;
    endtask : bus_rd
    // the bound is a little over one interval, so a dead tick ends the run
    task automatic wait_tick(input int n);
        for (int k = 0; k < n; k++) begin
            int i;
            for (i = 0; i < TI + 100; i++) begin
                @(posedge clk);
                #1;
                if (tick === 1'b1) break;
            end
            if (i == TI + 100) begin
                n_fail++;
                report_and_stop();
            end
        end
        repeat (3) @(posedge clk);
        #1;
    endtask : wait_tick
    task automatic chk_outs();
        logic [3:0] d;
        logic [3:0] l;
        d = 4'(m_cmd & m_dir & (m_en != 0 ? 15 : 0));
        l = m_run != 0 ? 4'((m_cmd & m_dir) | (m_in & m_used & ~m_dir)) : 4'h0;
        `CHK(oe_n, ~d, "driver enables")
        `CHK(t_out & ~oe_n, d, "driven levels")
        `CHK(led, l, "status leds")
    endtask : chk_outs
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ==========================================================
    // main sequence
    initial begin
        {nrst, wr, rd, addr, wdata, sensor, shorted} = '0;
        {gen, seed, n_fail, num_checks} = {1'b1, 32'd27689, 64'd0};
        {m_dir, m_cmd, m_used, m_run, m_in, m_en} = {160'd0, 32'd1};
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk_outs();
        bus_rd(ADDR_DIR);
        `CHK(rv[3:0], DIR_RESET, "direction after reset")
        bus_rd(8'h40);
        `CHK(rv, UNMAPPED_READ, "unmapped read")
        bus_wr(ADDR_IVAL, TI);
        bus_wr(ADDR_IVAL, 1000);
        bus_rd(ADDR_IVAL);
        `CHK(rv, 32'(TI), "interval setting")
        {m_dir, m_used, m_run} = {32'd1, 32'd2, 32'd1};
        m_cmd = int'(xorshift() & 32'hf) | 1;
        bus_wr(ADDR_DIR, m_dir);
        bus_wr(ADDR_USED, m_used);
        bus_wr(ADDR_CMD, m_cmd);
        bus_wr(ADDR_CTRL, 3);
        sensor <= 4'b1010;
        repeat (1250) @(posedge clk);
        sensor <= 4'b0010;
        wait_tick(3);
        m_in = 3;
        chk_outs();
        bus_rd(ADDR_INPUT);
        wdata <= rv; // first of two samples
        wait_tick(1);
        bus_rd(ADDR_INPUT);
        `CHK(rv[3:0] & wdata[3:0], 4'(m_in), "sampled inputs")
        bus_wr(ADDR_CMD, 0);
        repeat (5) @(posedge clk);
        #1;
        chk_outs();
        m_cmd = 0;
        wait_tick(1);
        chk_outs();
        m_cmd = 1;
        bus_wr(ADDR_CMD, 1);
        wait_tick(1);
        gen <= 1'b0;
        m_en = 0;
        repeat (8) @(posedge clk);
        #1;
        chk_outs();
        gen <= 1'b1;
        m_en = 1;
        bus_wr(ADDR_CTRL, 2);
        m_run = 0;
        wait_tick(1);
        chk_outs();
        bus_wr(ADDR_CTRL, 3);
        m_run = 1;
        wait_tick(1);
        shorted <= 4'h1;
        repeat (8) @(posedge clk);
        #1;
        `CHK(oe_n[0], 1'b1, "overload trip")
        bus_rd(ADDR_STATUS);
        `CHK(rv, 32'((m_en << 8) | 16 | m_dir), "status after trip")
        shorted <= 4'h0;
        repeat (40) @(posedge clk);
        wait_tick(1);
        chk_outs();
        report_and_stop();
    end
endmodule : fcdio_top_tb
